// file: common/wfs_map.svh
`ifndef WFS_MAP_SVH
`define WFS_MAP_SVH

// register indices as printed; byte address is four times the index
`define WFS_IDX_CTRL      8'h0C
`define WFS_IDX_SLOT_BASE 8'h0F
`define WFS_IDX_SLOT_LAST 8'h16
`define WFS_IDX_SLOT_SIX  8'h14
`define WFS_IDX_SLOT_SEVEN 8'h15

// field positions inside a slot and the control word
`define WFS_SLOT_DELAY_BIT 7
`define WFS_CTRL_START_BIT 0

// reset values
`define WFS_SLOT_RESET 8'h00

// timing: one delay unit is 10 ms, clock 50 MHz
`define WFS_UNIT_MS    10
`define WFS_CLK_KHZ    50000
`define WFS_UNIT_CYCLES (`WFS_UNIT_MS * `WFS_CLK_KHZ)

`endif

// file: common/wfs_pkg.sv
package wfs_pkg;

    // one slot entry: delay select over a 7-bit value
    typedef struct packed {
        logic       delaySel;
        logic [6:0] entryValue;
    } wfs_slot_t;

    // request handed to the waveform player
    typedef struct packed {
        logic       valid;
        logic [6:0] waveId;
    } wfs_play_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_FETCH,
        SEQ_PLAY,
        SEQ_DELAY
    } wfs_state_t;

endpackage : wfs_pkg

// file: rtl/wfs_slots.sv
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "wfs_map.svh"
module wfs_slots #(
    parameter int UNIT_CYCLES = `WFS_UNIT_CYCLES
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // waveform player
    output wfs_pkg::wfs_play_t     playReq,
    input  wire logic              waveDone,
    output logic                   seqBusy
);
    import wfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flops; rst_n may rise at any moment, so
    // the second flop gives every register below a release aligned to
    // core_clk, clear of its recovery window; only the second flop is read
    logic rstSync1_r;
    logic rstSync2_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end
        else
        begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end

    // synchronised reset used by everything below
    wire logic rstN = rstSync2_r;

    ////////////////////////////////////////////////////////////////////////
    // address decode: word index from byte address; the two low address
    // bits must be zero, anything else is answered as unmapped, which
    // keeps a half-word access from touching a neighbouring register
    localparam int NSLOT = 8;

    // slot table and sequencer state
    wfs_slot_t  slot_r [NSLOT];
    wfs_state_t state_r;
    logic [2:0] slotIdx_r;

    // decode of the current bus request
    logic [5:0] wordIdx;
    logic       hitCtrl;
    logic       hitSlot;
    logic       mapped;
    logic [2:0] slotSel;
    logic       accessDone;
    logic       wrStart;
    logic       wrSlot;

    // the entry being worked on and whether it is the final one
    wfs_slot_t  curSlot;
    logic       lastSlot;

    assign wordIdx = paddr[7:2];
    assign hitCtrl = ({2'h0, wordIdx} == `WFS_IDX_CTRL)
                  && (paddr[1:0] == 2'h0);
    assign hitSlot = ({2'h0, wordIdx} >= `WFS_IDX_SLOT_BASE)
                  && ({2'h0, wordIdx} <= `WFS_IDX_SLOT_LAST)
                  && (paddr[1:0] == 2'h0);
    assign mapped  = hitCtrl || hitSlot;
    // 0x0F..0x16 maps onto slot 0..7
    assign slotSel = 3'(wordIdx - 6'(`WFS_IDX_SLOT_BASE));
    // a write lands only at the edge that sees pready high
    assign accessDone = psel && penable && pready;
    assign wrStart = accessDone && pwrite && hitCtrl
                  && pwdata[`WFS_CTRL_START_BIT];
    // a slot write needs the same qualifiers, so a refused address can
    // never disturb the table
    assign wrSlot  = accessDone && pwrite && hitSlot && !pslverr;

    // the sequencer always looks at the entry its index points to
    assign curSlot  = slot_r[slotIdx_r];
    assign lastSlot = (slotIdx_r == 3'(NSLOT - 1));

    ////////////////////////////////////////////////////////////////////////
    // read word of the addressed register, zero where nothing is mapped
    logic [31:0] rdWord;

    always_comb
    begin
        rdWord = 32'h0000_0000;
        if (hitCtrl)
            rdWord = {31'h0, seqBusy};          // start bit reads busy
        else if (hitSlot)
            rdWord = {24'h0, slot_r[slotSel]};
    end

    // apb answer: prepared in the setup cycle so that pready, prdata and
    // pslverr come straight from flops and no wait state is ever needed;
    // the price is that a read returns the value as it stood at setup
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            // unmapped or misaligned: error answer, read zero, write dropped
            pready  <= 1'b1;
            pslverr <= !mapped;
            if (pwrite)
                prdata <= 32'h0000_0000;
            else
                prdata <= rdWord;
        end
        else
        begin
            // answer stands for exactly the access cycle
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slot storage, all eight entries share one layout; only the low
    // byte of the write word is kept, the upper bits have no home
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            for (int i = 0; i < NSLOT; i++)
                slot_r[i] <= `WFS_SLOT_RESET;
        end
        else if (wrSlot)
        begin
            // delay select and value are stored as two separate fields
            slot_r[slotSel].delaySel   <= pwdata[`WFS_SLOT_DELAY_BIT];
            slot_r[slotSel].entryValue <= pwdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay timer: unit prescaler and remaining unit count; the prescaler
    // restarts at every fetch, so a delay is always whole units long,
    // and a value of N idles N units plus one cycle; the prescaler is
    // kept 32 bits wide so that any sensible clock rate fits
    logic [31:0] tickCnt_r;
    logic [6:0]  unitsLeft_r;
    logic        delayEnd;

    assign delayEnd = (state_r == SEQ_DELAY) && (unitsLeft_r == 7'h00);

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            tickCnt_r   <= 32'h0000_0000;
            unitsLeft_r <= 7'h00;
        end
        else if (state_r == SEQ_FETCH)
        begin
            // load the count from the entry being fetched
            tickCnt_r   <= 32'h0000_0000;
            unitsLeft_r <= curSlot.entryValue;
        end
        else if (state_r == SEQ_DELAY && unitsLeft_r != 7'h00)
        begin
            // each unit is UNIT_CYCLES clocks, i.e. 10 ms at 50 MHz
            if (tickCnt_r == 32'(UNIT_CYCLES - 1))
            begin
                tickCnt_r   <= 32'h0000_0000;
                unitsLeft_r <= unitsLeft_r - 7'h01;
            end
            else
                tickCnt_r <= tickCnt_r + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: FETCH looks at an entry for one cycle, then PLAY waits
    // for the player's done pulse or DELAY waits out the timer; both go
    // on to the next entry's FETCH, or to IDLE after the eighth, so a
    // run never touches more than eight entries
    logic stepDone;

    // a done pulse outside PLAY is ignored, so a stray pulse during a
    // delay or a fetch cannot skip an entry
    assign stepDone = (state_r == SEQ_PLAY && waveDone) || delayEnd;

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_r   <= SEQ_IDLE;
            slotIdx_r <= 3'h0;
        end
        else
        begin
            case (state_r)
                SEQ_IDLE:
                begin
                    // only a start write leaves idle; a start while busy
                    // is dropped, so a run cannot restart in mid-sequence
                    if (wrStart)
                    begin
                        slotIdx_r <= 3'h0;
                        state_r   <= SEQ_FETCH;
                    end
                end
                SEQ_FETCH:
                begin
                    // a zero value ends the run before anything plays,
                    // whatever the delay select says
                    if (curSlot.entryValue == 7'h00)
                        state_r <= SEQ_IDLE;
                    else if (curSlot.delaySel)
                        state_r <= SEQ_DELAY;
                    else
                        state_r <= SEQ_PLAY;
                end
                SEQ_PLAY, SEQ_DELAY:
                begin
                    // waveform and delay entries share one advance path
                    if (stepDone)
                    begin
                        if (lastSlot)
                            state_r <= SEQ_IDLE;
                        else
                        begin
                            slotIdx_r <= slotIdx_r + 3'h1;
                            state_r   <= SEQ_FETCH;
                        end
                    end
                end
                // an unused code falls back to idle
                default:
                    state_r <= SEQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // player request: level held for the whole waveform, cleared on done;
    // the identifier goes out untouched, the library lookup by index
    // belongs to the player, which keeps this block free of the library
    // size
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            playReq <= '0;
        else if (state_r == SEQ_FETCH && !curSlot.delaySel
                 && curSlot.entryValue != 7'h00)
        begin
            // only a playable entry raises the request
            playReq.valid  <= 1'b1;
            playReq.waveId <= curSlot.entryValue;
        end
        // the done pulse drops it; the next fetch may raise it again
        else if (state_r == SEQ_PLAY && waveDone)
            playReq.valid <= 1'b0;
    end

    // busy covers the start edge too, so a read right after start shows 1;
    // it falls at the same edge at which the sequencer returns to idle,
    // so software polling the bit never sees idle while a step is open;
    // there is no way to stop a run early, the bit only reports
    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
            seqBusy <= 1'b0;
        else if (state_r == SEQ_IDLE)
            seqBusy <= wrStart;
        else if (state_r == SEQ_FETCH)
            seqBusy <= curSlot.entryValue != 7'h00;
        else if (stepDone && lastSlot)
            seqBusy <= 1'b0;
    end

endmodule : wfs_slots

// file: verification/wfs_slots_assertions.sv
`timescale 1ns/1ns
module wfs_slots_checker #(
    parameter int UNIT_CYCLES = 4
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // player
    input wire wfs_pkg::wfs_play_t playReq,
    input wire logic              waveDone,
    input wire logic              seqBusy
);
    import wfs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // bus answers, zero wait states
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_map; psel && !penable && paddr == 8'h50 |=> !pslverr;
    endproperty
    a_map: assert property (p_map) else $error("slot error");
    property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits");
    // start only takes effect while idle
    property p_go; psel && penable && pwrite && paddr == 8'h30
        && pwdata[0] && !seqBusy |=> seqBusy; endproperty
    a_go: assert property (p_go) else $error("no start");
    // a finished waveform leaves a fetch gap before the next one
    property p_gap; playReq.valid && waveDone |=> !playReq.valid;
    endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_id; playReq.valid && $past(playReq.valid)
        |-> $stable(playReq.waveId); endproperty
    a_id: assert property (p_id) else $error("id moved");
    property p_nz; playReq.valid |-> playReq.waveId != 7'h0; endproperty
    a_nz: assert property (p_nz) else $error("zero id");
    property p_idle; !seqBusy |-> !playReq.valid; endproperty
    a_idle: assert property (p_idle) else $error("idle play");
endmodule : wfs_slots_checker
////////////////////////////////////////////////////////////////////////////////
bind wfs_slots wfs_slots_checker #(.UNIT_CYCLES(UNIT_CYCLES)) uChk (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .playReq(playReq),
    .waveDone(waveDone), .seqBusy(seqBusy));

// file: verification/test_waveform_sequence_slots.sv
`timescale 1ns/1ns
module test_waveform_sequence_slots;
    import wfs_pkg::*;
    // short delay unit keeps the run brief
    localparam int UNIT = 4;
    logic        core_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wfs_play_t   playReq;
    logic        waveDone;
    logic        seqBusy;
    int          errorCnt;
    int          checks;
    wfs_slots #(.UNIT_CYCLES(UNIT)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .playReq(playReq),
        .waveDone(waveDone), .seqBusy(seqBusy));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // edges until play starts, or until busy drops
    task automatic countTo(input logic busyEnd, output int n);
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end while ((busyEnd ? seqBusy : !playReq.valid) !== 1'b0 && n < 999);
    endtask : countTo
    task automatic runSeq(input logic [7:0] s [8]);
        logic [31:0] q;
        logic        e;
        int          n;
        int          g;
        int          i;
        g = 1;
        for (i = 0; i < 8; i++)
            apb(1'b1, 8'h3C + 8'(4 * i), {24'h0, s[i]}, q, e);
        apb(1'b1, 8'h30, 32'h1, q, e);
        // delays only widen the gap before the next fetch
        for (i = 0; i < 8 && s[i][6:0] != 7'h0; i++)
        begin
            if (s[i][7])
                g += 2 + UNIT * s[i][6:0];
            else
            begin
                countTo(1'b0, n);
                chk(32'(n), 32'(g));
                chk(32'(playReq.waveId), 32'(s[i][6:0]));
                if (i == 0)
                begin
                    // a start while busy must be dropped
                    apb(1'b1, 8'h30, 32'h1, q, e);
                    apb(1'b0, 8'h30, 32'h0, q, e);
                    chk(q, 32'h1);
                end
                g = 1;
                @(posedge core_clk);
                waveDone <= 1'b1;
                @(posedge core_clk);
                waveDone <= 1'b0;
            end
        end
        countTo(1'b1, n);
        if (i < 8)
            chk(32'(n), 32'(g));
        chk(32'(playReq.valid), 32'h0);
    endtask : runSeq
    task automatic sRegs;
        logic [31:0] q;
        logic        e;
        apb(1'b0, 8'h50, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b0, 8'h54, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b1, 8'h50, 32'hFFFFFFA5, q, e);
        apb(1'b1, 8'h54, 32'h5A, q, e);
        apb(1'b0, 8'h50, 32'h0, q, e);
        chk(q, 32'hA5);
        apb(1'b0, 8'h54, 32'h0, q, e);
        chk(q, 32'h5A);
        apb(1'b0, 8'hFC, 32'h0, q, e);
        chk({e, q[30:0]}, 32'h80000000);
    endtask : sRegs
    task automatic sEight;
        runSeq('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h82, 8'h07, 8'h7F});
    endtask : sEight
    task automatic sZero;
        runSeq('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h06, 8'h83, 8'h00});
    endtask : sZero
    task automatic conclude;
        $display("errors %0d checks %0d", errorCnt, checks);
        if (errorCnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // whole run is well under a thousand cycles
    initial
    begin
        #400000;
        errorCnt++;
        conclude();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, waveDone} = 5'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        sRegs();
        sEight();
        sZero();
        conclude();
    end
endmodule : test_waveform_sequence_slots
